// [src/esol_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a 32-bit APB register bus
`ifndef ESOL_REGS_SVH
`define ESOL_REGS_SVH

// register byte offsets
`define ESOL_OFS_CTRL      8'h00
`define ESOL_OFS_CRANK_SPD 8'h04
`define ESOL_OFS_LOAD_SPD  8'h08
`define ESOL_OFS_COOL_DLY  8'h0C
`define ESOL_OFS_KICK      8'h10
`define ESOL_OFS_STATUS    8'h14

// control register fields
`define ESOL_CTRL_VARIANT  0
`define ESOL_CTRL_FUEL_GAS 1

// status register fields
`define ESOL_ST_RUNNING    0
`define ESOL_ST_IGNITION   1
`define ESOL_ST_UNLOAD     2
`define ESOL_ST_COOLING    3
`define ESOL_ST_FUEL       4
`define ESOL_ST_PUMP       5
`define ESOL_ST_ALIVE      6
`define ESOL_ST_LOAD       7
`define ESOL_ST_FW_OK      8

// reset values
`define ESOL_RST_CTRL      2'h0
`define ESOL_RST_CRANK_SPD 16'h0190
`define ESOL_RST_LOAD_SPD  16'h0320
`define ESOL_RST_COOL_DLY  16'h003C

// timing
`define ESOL_CLK_PERIOD_NS  100
`define ESOL_TICK_PERIOD_NS 10000000
`define ESOL_TICK_MS        10
`define ESOL_UNLOAD_MS      1000
`define ESOL_ALIVE_HALF_MS  250
`define ESOL_ALIVE_TMO_MS   1000
`define ESOL_IGN_RPM        16'h001E
`define ESOL_MS_PER_SEC     1000

`endif

// [src/esol_pkg.sv]
// types shared by the engine state output logic
// assumes the sequencer reports its state with these codes
package esol_pkg;
   // engine sequence state as reported by the sequencer
   typedef enum logic [2:0] {
      ESOL_SEQ_IDLE  = 3'b000,
      ESOL_SEQ_CRANK = 3'b001,
      ESOL_SEQ_PAUSE = 3'b010,
      ESOL_SEQ_RUN   = 3'b011,
      ESOL_SEQ_COOL  = 3'b100,
      ESOL_SEQ_STOP  = 3'b101
   } esol_seq_t;

   // unload pulse sequencing
   typedef enum logic [1:0] {
      ESOL_UL_IDLE  = 2'b00,
      ESOL_UL_PULSE = 2'b01,
      ESOL_UL_GO    = 2'b10
   } esol_ul_t;
endpackage

// [src/esol_sync.sv]
// two-flop synchroniser with rising edge detect
// assumes inputs may change at any time relative to clk_i
`timescale 1ns/1ps
module esol_sync #(
   parameter int W = 2
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o,
   output logic      [W-1:0] rise_o
);
   logic [W-1:0] meta_reg;   // first stage, read only by second
   logic [W-1:0] sync_reg;   // settled level
   logic [W-1:0] prev_reg;   // for edge detect

   // synchroniser chain
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o  = sync_reg & ~prev_reg;
endmodule

// [src/esol_tick.sv]
// prescaler giving one pulse per tick period
// assumes a free-running system clock
`timescale 1ns/1ps
module esol_tick #(
   parameter int TICK_CYCLES = 100000
) (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   output logic      tick_o
);
   logic [23:0] cnt_reg;   // cycles left in this tick

   // refuse counts the counter cannot hold
   if (TICK_CYCLES < 2 || TICK_CYCLES > 16777215) begin : g_chk
      $error("esol_tick: TICK_CYCLES out of range");
   end

   // down counter, pulse on wrap
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 24'h000000;
         tick_o  <= 1'b0;
      end else if (cnt_reg == 24'h000000) begin
         cnt_reg <= 24'(TICK_CYCLES - 1);
         tick_o  <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg - 24'h000001;
         tick_o  <= 1'b0;
      end
   end
endmodule

// [src/esol_top.sv]
// engine state output logic: running, ignition, unload, cooling, fuel,
// coolant pump, alive toggle and load-close outputs, set up over APB
// assumes speed and sequence state are synchronous to clk_i
`timescale 1ns/1ps
`include "esol_regs.svh"
module esol_top import esol_pkg::*; #(
   parameter int TICK_CYCLES = `ESOL_TICK_PERIOD_NS / `ESOL_CLK_PERIOD_NS
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // engine side
   input  wire logic [15:0] speed_i,          // measured rpm
   input  wire logic [2:0]  seq_state_i,      // sequencer state code
   input  wire logic        stop_req_i,       // sequencer wants to leave running
   input  wire logic        panel_button_i,   // on/off button
   input  wire logic        remote_run_input_i,
   input  wire logic        remote_release_i,
   input  wire logic        remote_open_i,    // remote open command
   output logic             cool_go_o,        // sequencer may enter cooling
   output logic             running_o,
   output logic             ignition_o,
   output logic             unload_o,
   output logic             cooling_o,
   output logic             fuel_o,
   output logic             pump_o,
   output logic             alive_o,
   output logic             load_o
);
   localparam logic [23:0] UL_TICKS  = 24'(`ESOL_UNLOAD_MS / `ESOL_TICK_MS);
   localparam logic [23:0] HALF_TKS  = 24'(`ESOL_ALIVE_HALF_MS / `ESOL_TICK_MS);
   localparam logic [23:0] TMO_TICKS = 24'(`ESOL_ALIVE_TMO_MS / `ESOL_TICK_MS);

   // milliseconds to ticks, cut to counter width
   function automatic logic [23:0] ms_to_ticks(input logic [31:0] ms);
      logic [31:0] t;
      t = ms / 32'(`ESOL_TICK_MS);
      return t[23:0];
   endfunction

   logic        tick;            // one pulse per tick
   logic [3:0]  in_lvl;          // synchronised levels
   logic [3:0]  in_rise;         // synchronised rising edges
   logic        btn_rise;        // panel button press
   logic        rem_lvl;         // remote run closed
   logic        rem_rise;        // remote run closing
   logic        rel_lvl;         // remote release closed
   logic        ropen_rise;      // remote open command
   esol_seq_t   seq;             // decoded sequencer state
   logic        spd_zero;        // engine stopped
   logic        above_load;      // above permit speed
   logic        below_load;      // below permit speed

   // configuration and status registers
   logic [1:0]  ctrl_reg;        // variant and fuel mode
   logic [15:0] crank_spd_reg;   // crank success speed
   logic [15:0] load_spd_reg;    // load permit speed
   logic [15:0] cool_dly_reg;    // post stop coolant delay, seconds
   logic        running_reg;
   logic        ignition_reg;
   logic        unload_reg;
   logic        cooling_reg;
   logic        fuel_reg;
   logic        pump_reg;
   logic        alive_reg;
   logic        load_reg;
   logic        cool_go_reg;
   esol_ul_t    ul_reg;          // unload sequencing state
   logic [23:0] ul_cnt_reg;      // unload ticks elapsed
   logic [23:0] pump_cnt_reg;    // coolant ticks left
   logic [23:0] alive_cnt_reg;   // ticks to next toggle
   logic [23:0] tmo_cnt_reg;     // ticks of firmware life left
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        wr_en;           // write in access phase
   logic        rd_en;           // read in access phase
   logic        hit;             // mapped address

   // inputs through the synchroniser before any edge is looked at
   esol_sync #(.W(4)) u_sync (
      .clk_i    (clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i  ({remote_open_i, remote_release_i, remote_run_input_i,
                  panel_button_i}),
      .level_o  (in_lvl),
      .rise_o   (in_rise)
   );

   // tick source for all second-scale timing
   esol_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk_i    (clk_i),
      .sys_rst_i(sys_rst_i),
      .tick_o   (tick)
   );

   assign btn_rise   = in_rise[0];
   assign rem_lvl    = in_lvl[1];
   assign rem_rise   = in_rise[1];
   assign rel_lvl    = in_lvl[2];
   assign ropen_rise = in_rise[3];
   assign seq        = esol_seq_t'(seq_state_i);
   assign spd_zero   = (speed_i == 16'h0000);
   assign above_load = (speed_i > load_spd_reg);
   assign below_load = (speed_i < load_spd_reg);

   // apb decode; the extra wait state lets every answer come from a flop
   assign wr_en = psel_i & penable_i & pwrite_i & ~pready_reg;
   assign rd_en = psel_i & penable_i & ~pwrite_i & ~pready_reg;
   always_comb begin
      case (paddr_i)
         `ESOL_OFS_CTRL, `ESOL_OFS_CRANK_SPD, `ESOL_OFS_LOAD_SPD,
         `ESOL_OFS_COOL_DLY, `ESOL_OFS_KICK, `ESOL_OFS_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // apb answer: ready one cycle into access, error on unmapped
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= wr_en | rd_en;
         pslverr_reg <= (wr_en | rd_en) & ~hit;
         if (rd_en) begin
            case (paddr_i)
               `ESOL_OFS_CTRL:      prdata_reg <= {30'h00000000, ctrl_reg};
               `ESOL_OFS_CRANK_SPD: prdata_reg <= {16'h0000, crank_spd_reg};
               `ESOL_OFS_LOAD_SPD:  prdata_reg <= {16'h0000, load_spd_reg};
               `ESOL_OFS_COOL_DLY:  prdata_reg <= {16'h0000, cool_dly_reg};
               `ESOL_OFS_STATUS:    prdata_reg <= {23'h000000,
                  tmo_cnt_reg != 24'h000000, load_reg, alive_reg, pump_reg,
                  fuel_reg, cooling_reg, unload_reg, ignition_reg, running_reg};
               default:             prdata_reg <= 32'h00000000;  // kick reads zero
            endcase
         end else begin
            prdata_reg <= 32'h00000000;
         end
      end
   end

   // configuration writes
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_reg      <= `ESOL_RST_CTRL;
         crank_spd_reg <= `ESOL_RST_CRANK_SPD;
         load_spd_reg  <= `ESOL_RST_LOAD_SPD;
         cool_dly_reg  <= `ESOL_RST_COOL_DLY;
      end else if (wr_en) begin
         case (paddr_i)
            `ESOL_OFS_CTRL:      ctrl_reg      <= pwdata_i[1:0];
            `ESOL_OFS_CRANK_SPD: crank_spd_reg <= pwdata_i[15:0];
            `ESOL_OFS_LOAD_SPD:  load_spd_reg  <= pwdata_i[15:0];
            `ESOL_OFS_COOL_DLY:  cool_dly_reg  <= pwdata_i[15:0];
            default: ;                        // kick and status store nothing
         endcase
      end
   end

   // engine running; zero speed wins so a stalled engine always clears
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         running_reg <= 1'b0;
      end else if (spd_zero) begin
         running_reg <= 1'b0;
      end else if (speed_i > crank_spd_reg) begin
         running_reg <= 1'b1;
      end
   end

   // ignition follows cranking above the firing threshold
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ignition_reg <= 1'b0;
      end else if (seq == ESOL_SEQ_PAUSE || spd_zero) begin
         ignition_reg <= 1'b0;
      end else if (seq == ESOL_SEQ_CRANK && speed_i > `ESOL_IGN_RPM) begin
         ignition_reg <= 1'b1;
      end
   end

   // unload pulse; the sequencer waits for cool_go before it changes state
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ul_reg      <= ESOL_UL_IDLE;
         ul_cnt_reg  <= 24'h000000;
         unload_reg  <= 1'b0;
         cool_go_reg <= 1'b0;
      end else begin
         case (ul_reg)
            ESOL_UL_IDLE: begin
               cool_go_reg <= 1'b0;
               ul_cnt_reg  <= 24'h000000;
               if (stop_req_i && seq == ESOL_SEQ_RUN) begin
                  ul_reg     <= ESOL_UL_PULSE;
                  unload_reg <= 1'b1;
               end
            end
            ESOL_UL_PULSE: begin
               // length is fixed; not a setting
               if (tick) begin
                  ul_cnt_reg <= ul_cnt_reg + 24'h000001;
               end
               if (tick && ul_cnt_reg == UL_TICKS - 24'h000001) begin
                  ul_reg      <= ESOL_UL_GO;
                  unload_reg  <= 1'b0;
                  cool_go_reg <= 1'b1;
               end
            end
            ESOL_UL_GO: begin
               cool_go_reg <= 1'b0;
               ul_reg      <= ESOL_UL_IDLE;
            end
            default: begin
               ul_reg      <= ESOL_UL_IDLE;
               unload_reg  <= 1'b0;
               cool_go_reg <= 1'b0;
            end
         endcase
      end
   end

   // cooling output held through the cooling state until speed is zero
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cooling_reg <= 1'b0;
      end else if (spd_zero) begin
         cooling_reg <= 1'b0;
      end else if (seq == ESOL_SEQ_COOL) begin
         cooling_reg <= 1'b1;
      end
   end

   // fuel valve: diesel opens from cranking on, gas waits for firing speed
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fuel_reg <= 1'b0;
      end else begin
         case (seq)
            ESOL_SEQ_CRANK: fuel_reg <= ctrl_reg[`ESOL_CTRL_FUEL_GAS] ?
                                        (speed_i > `ESOL_IGN_RPM) : 1'b1;
            ESOL_SEQ_RUN,
            ESOL_SEQ_COOL:  fuel_reg <= 1'b1;
            default:        fuel_reg <= 1'b0;
         endcase
      end
   end

   // coolant pump with post-stop run-on counted in ticks
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pump_reg     <= 1'b0;
         pump_cnt_reg <= 24'h000000;
      end else if (!spd_zero && speed_i > crank_spd_reg) begin
         pump_reg     <= 1'b1;
         pump_cnt_reg <= ms_to_ticks(32'(cool_dly_reg) * `ESOL_MS_PER_SEC);
      end else if (spd_zero && !running_reg && pump_reg) begin
         // run-on after stop; a zero delay drops the pump at once
         if (pump_cnt_reg == 24'h000000) begin
            pump_reg <= 1'b0;
         end else if (tick) begin
            pump_cnt_reg <= pump_cnt_reg - 24'h000001;
         end
      end
   end

   // firmware life: each kick write restores the timeout
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tmo_cnt_reg <= 24'h000000;
      end else if (wr_en && paddr_i == `ESOL_OFS_KICK) begin
         tmo_cnt_reg <= TMO_TICKS;
      end else if (tick && tmo_cnt_reg != 24'h000000) begin
         tmo_cnt_reg <= tmo_cnt_reg - 24'h000001;
      end
   end

   // alive toggle, frozen once firmware stops kicking
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         alive_reg     <= 1'b0;
         alive_cnt_reg <= HALF_TKS;
      end else if (tmo_cnt_reg != 24'h000000 && tick) begin
         if (alive_cnt_reg == 24'h000001) begin
            alive_reg     <= ~alive_reg;
            alive_cnt_reg <= HALF_TKS;
         end else begin
            alive_cnt_reg <= alive_cnt_reg - 24'h000001;
         end
      end
   end

   // load close; opening on low speed has top priority in both variants
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         load_reg <= 1'b0;
      end else if (below_load) begin
         load_reg <= 1'b0;
      end else if (!ctrl_reg[`ESOL_CTRL_VARIANT]) begin
         if (rem_lvl && above_load) begin
            load_reg <= 1'b1;
         end else if (btn_rise && load_reg && !rem_lvl) begin
            load_reg <= 1'b0;
         end else if (btn_rise && above_load) begin
            load_reg <= 1'b1;
         end
      end else begin
         if (ropen_rise && rel_lvl) begin
            load_reg <= 1'b0;
         end else if ((rem_rise || btn_rise) && load_reg) begin
            load_reg <= 1'b0;
         end else if ((rem_rise || btn_rise) && seq == ESOL_SEQ_RUN && above_load) begin
            load_reg <= 1'b1;
         end
      end
   end

   assign prdata_o   = prdata_reg;
   assign pready_o   = pready_reg;
   assign pslverr_o  = pslverr_reg;
   assign cool_go_o  = cool_go_reg;
   assign running_o  = running_reg;
   assign ignition_o = ignition_reg;
   assign unload_o   = unload_reg;
   assign cooling_o  = cooling_reg;
   assign fuel_o     = fuel_reg;
   assign pump_o     = pump_reg;
   assign alive_o    = alive_reg;
   assign load_o     = load_reg;

   // checks next to the logic they guard
   sequence s_ul_end;
      unload_reg ##1 !unload_reg;
   endsequence

   property p_ul_len;
      @(posedge clk_i) disable iff (sys_rst_i)
         s_ul_end |-> cool_go_reg && ul_cnt_reg == UL_TICKS;
   endproperty

   a_run_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      spd_zero |=> !running_reg) else $error("running not cleared at zero");
   a_run_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !spd_zero && speed_i > crank_spd_reg |=> running_reg)
      else $error("running not set above crank speed");
   a_ign_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      seq == ESOL_SEQ_CRANK && speed_i > `ESOL_IGN_RPM |=> ignition_reg)
      else $error("ignition not set while cranking");
   a_ign_pause: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      seq == ESOL_SEQ_PAUSE || spd_zero |=> !ignition_reg)
      else $error("ignition not cleared");
   a_unload_len: assert property (p_ul_len)
      else $error("unload pulse length wrong");
   a_cool_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      seq == ESOL_SEQ_COOL && !spd_zero |=> cooling_reg)
      else $error("cooling not set on entry");
   a_pump_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $fell(running_reg) && cool_dly_reg != 16'h0000 |-> pump_reg[*3])
      else $error("pump dropped at stop");
   a_alive_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      tmo_cnt_reg == 24'h000000 |=> $stable(alive_reg))
      else $error("alive toggled without firmware");
   a_load_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      below_load |=> !load_reg) else $error("load not opened below permit");
   a_load_remote: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !ctrl_reg[`ESOL_CTRL_VARIANT] && rem_lvl && above_load |=> load_reg)
      else $error("load opened while remote closed");
   a_load_var_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $past(ctrl_reg[`ESOL_CTRL_VARIANT]) && $rose(load_reg) |-> $past(seq) == ESOL_SEQ_RUN)
      else $error("load closed outside running");
endmodule

// [verification/esol_engine.sv]
// engine stand-in: speed pickup and sequencer state for the output logic
// assumes the bench changes its commands right after a rising edge
`timescale 1ns/1ps
module esol_engine import esol_pkg::*; (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [15:0] rpm_cmd_i,  // wanted speed
   input  wire logic [2:0]  seq_cmd_i,  // wanted state
   input  wire logic        seq_load_i, // take seq_cmd_i
   input  wire logic        cool_go_i,  // unload pulse finished
   output logic      [15:0] speed_o,    // measured rpm
   output logic      [2:0]  seq_o       // sequencer state
);
   // pickup lags one cycle, like a filtered sensor
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         speed_o <= 16'h0000;
      end else begin
         speed_o <= rpm_cmd_i;
      end
   end
   // cooling is entered after the unload handshake or by loading its state code; cool_go wins over seq_load_i
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         seq_o <= ESOL_SEQ_IDLE;
      end else if (cool_go_i) begin
         seq_o <= ESOL_SEQ_COOL;
      end else if (seq_load_i) begin
         seq_o <= seq_cmd_i;
      end
   end
endmodule

// [verification/test_engine_state_output_logic.sv]
// bench for the engine state output logic: apb, engine and operator inputs
// assumes a short tick of 4 clocks so one second is 400 clocks
`timescale 1ns/1ps
`include "esol_regs.svh"
module test_engine_state_output_logic import esol_pkg::*;;
   logic        clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0;
   logic        penable_i = 1'b0, pwrite_i = 1'b0, stop_req_i = 1'b0;
   logic [7:0]  paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic        pready_o, pslverr_o, cool_go_o, running_o, ignition_o, unload_o;
   logic        cooling_o, fuel_o, pump_o, alive_o, load_o, err, seq_load = 1'b0;
   logic [15:0] speed_i, rpm_cmd = 16'h0;
   logic [2:0]  seq_state_i, seq_cmd = 3'h0;
   logic [3:0]  op = 4'h0; // button, remote run, release, remote open
   int          error_cnt = 0, total_checks = 0, n;
   always #50 clk_i = ~clk_i;
   esol_top #(.TICK_CYCLES(4)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .speed_i(speed_i), .seq_state_i(seq_state_i),
      .stop_req_i(stop_req_i), .panel_button_i(op[0]), .remote_run_input_i(op[1]),
      .remote_release_i(op[2]), .remote_open_i(op[3]), .cool_go_o(cool_go_o),
      .running_o(running_o), .ignition_o(ignition_o), .unload_o(unload_o),
      .cooling_o(cooling_o), .fuel_o(fuel_o), .pump_o(pump_o), .alive_o(alive_o),
      .load_o(load_o));
   esol_engine ENG (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rpm_cmd_i(rpm_cmd),
      .seq_cmd_i(seq_cmd), .seq_load_i(seq_load), .cool_go_i(cool_go_o),
      .speed_o(speed_i), .seq_o(seq_state_i));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // bounded wait for a level; running out ends the run
   task automatic wait_for(ref logic s, input logic v, input int lim);
      for (n = 0; n < lim && s !== v; n++) @(posedge clk_i);
      if (n == lim) begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   // one apb transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      wait_for(pready_o, 1'b1, 20);
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic eng(input logic [2:0] s, input logic [15:0] r);
      seq_cmd  <= s;
      rpm_cmd  <= r;
      seq_load <= 1'b1;
      @(posedge clk_i);
      seq_load <= 1'b0;
      cyc(4);
   endtask
   // pulse long enough to pass the synchroniser
   task automatic press(input int k);
      op[k] <= 1'b1;
      cyc(6);
      op[k] <= 1'b0;
      cyc(6);
   endtask
   task automatic s_regs();
      logic [7:0]  a [4] = '{`ESOL_OFS_CTRL, `ESOL_OFS_CRANK_SPD, `ESOL_OFS_LOAD_SPD,
                             `ESOL_OFS_COOL_DLY};
      logic [31:0] e [4] = '{32'h0, 32'h190, 32'h320, 32'h3C};
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, a[i], 32'h0);
         chk(rd, e[i]);
      end
      apb(1'b0, 8'h18, 32'h0); // unmapped
      chk(err, 1'b1);
      chk(rd, 32'h0);
   endtask
   task automatic s_start();
      eng(ESOL_SEQ_CRANK, 16'd30);
      chk({running_o, ignition_o, fuel_o}, 3'b001);
      eng(ESOL_SEQ_CRANK, 16'd31);
      chk(ignition_o, 1'b1);
      eng(ESOL_SEQ_PAUSE, 16'd31);
      chk(ignition_o, 1'b0);
      eng(ESOL_SEQ_CRANK, 16'h190);
      chk({running_o, ignition_o}, 2'b01);
      eng(ESOL_SEQ_CRANK, 16'h191);
      chk(running_o, 1'b1);
      eng(ESOL_SEQ_IDLE, 16'h0);
      chk({running_o, ignition_o}, 2'b00);
      apb(1'b1, `ESOL_OFS_CTRL, 32'h2);
      eng(ESOL_SEQ_CRANK, 16'd30);
      chk(fuel_o, 1'b0);
      eng(ESOL_SEQ_IDLE, 16'h0);
      apb(1'b1, `ESOL_OFS_CTRL, 32'h0);
   endtask
   task automatic s_stop();
      apb(1'b1, `ESOL_OFS_COOL_DLY, 32'h2);
      eng(ESOL_SEQ_RUN, 16'd1000);
      chk({running_o, pump_o, fuel_o}, 3'b111);
      stop_req_i <= 1'b1;
      @(posedge clk_i);
      stop_req_i <= 1'b0;
      wait_for(unload_o, 1'b1, 5);
      wait_for(unload_o, 1'b0, 500);
      chk(cool_go_o, 1'b1);
      chk(n >= 395 && n <= 405, 1'b1);
      cyc(3);
      chk({cooling_o, unload_o}, 2'b10);
      rpm_cmd <= 16'h0;
      cyc(4);
      chk({cooling_o, running_o, pump_o}, 3'b001);
      wait_for(pump_o, 1'b0, 1000);
      chk(n >= 790 && n <= 810, 1'b1);
      apb(1'b0, `ESOL_OFS_STATUS, 32'h0);
      chk(rd, 32'h00000010);
   endtask
   task automatic s_alive();
      apb(1'b1, `ESOL_OFS_KICK, 32'h1);
      wait_for(alive_o, ~alive_o, 150);
      wait_for(alive_o, ~alive_o, 150);
      chk(n >= 96 && n <= 104, 1'b1);
      cyc(400);
      err = alive_o;
      cyc(300);
      chk(alive_o, err);
   endtask
   task automatic s_load(input logic v);
      apb(1'b1, `ESOL_OFS_CTRL, {31'h0, v});
      eng(v ? ESOL_SEQ_COOL : ESOL_SEQ_RUN, 16'd1000);
      if (!v) begin
         op[1] <= 1'b1;
         cyc(6);
         chk(load_o, 1'b1);
         press(0);
         chk(load_o, 1'b1);
         op[1] <= 1'b0;
         press(0);
         chk(load_o, 1'b0);
         press(0);
         chk(load_o, 1'b1);
         eng(ESOL_SEQ_RUN, 16'd799);
         chk(load_o, 1'b0);
      end else begin
         press(0);
         chk(load_o, 1'b0);
         eng(ESOL_SEQ_RUN, 16'd1000);
         press(0);
         chk(load_o, 1'b1);
         press(1);
         chk(load_o, 1'b0);
         press(1);
         chk(load_o, 1'b1);
         op[2] <= 1'b1;
         press(3);
         chk(load_o, 1'b0);
      end
   endtask
   initial begin
      cyc(3);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      s_regs();
      s_start();
      s_stop();
      s_alive();
      s_load(1'b0);
      s_load(1'b1);
      report_and_stop();
   end
   initial begin
      #8000000;
      error_cnt++;
      report_and_stop();
   end
endmodule
